// ===== hdl/rcr_pkg.sv
/*
  Constants for the remote capability register bank: offsets, field
  positions, reset values and the fast control channel mode codes.
  Assumes an 8-bit register access port decoded by the I2C target logic.
*/
package rcr_pkg;

  // ----------------------------------------------------------------
  // Offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RCR_PORT_SEL_ADDR = 8'h1e;
  localparam logic [7:0] RCR_CAP_LO_ADDR   = 8'h20;
  localparam logic [7:0] RCR_CAP_HI_ADDR   = 8'h21;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RCR_LO_FREEZE   = 7;
  localparam int RCR_LO_MODE0    = 6;
  localparam int RCR_LO_TWO_LINK = 3;
  localparam int RCR_LO_CHANNEL  = 2;
  localparam int RCR_LO_WIDE_VID = 1;
  localparam int RCR_LO_FWD_GPIO = 0;
  localparam int RCR_HI_CRC      = 3;
  localparam int RCR_HI_MODE_MSB = 1;
  localparam int RCR_HI_MODE_LSB = 0;
  localparam int RCR_PS_ALT_ADDR = 2;
  localparam int RCR_PS_SECOND   = 1;
  localparam int RCR_PS_FIRST    = 0;

  // Writable bits of each register
  localparam logic [7:0] RCR_LO_MASK = 8'hcf;
  localparam logic [7:0] RCR_HI_MASK = 8'h0b;
  localparam logic [7:0] RCR_PS_MASK = 8'h07;
  // Bits loaded by the back channel (all but freeze and crc enable)
  localparam logic [7:0] RCR_LO_AUTO = 8'h4f;
  localparam logic [7:0] RCR_HI_AUTO = 8'h03;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RCR_CAP_RESET = 8'h00;
  localparam logic [7:0] RCR_PS_RESET  = 8'h01;

  // ----------------------------------------------------------------
  // Fast control channel modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCR_MODE_NORMAL   = 3'h0,
    RCR_MODE_GPIO1    = 3'h1,
    RCR_MODE_GPIO2    = 3'h2,
    RCR_MODE_GPIO4    = 3'h3,
    RCR_MODE_RSVD4    = 3'h4,
    RCR_MODE_RSVD5    = 3'h5,
    RCR_MODE_FWD_SPI  = 3'h6,
    RCR_MODE_REV_SPI  = 3'h7
  } rcr_mode_e;

endpackage

// ===== hdl/rcr_cap_store.sv
/*
  Per-port capability storage: two ports, two bytes each, registered
  read data. Assumes software writes arrive on clk; back-channel loads stay in rcr_top.
*/
`timescale 1ns/1ps
module rcr_cap_store
  import rcr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] wr_port,
  input  wire logic       wr_hi,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] wr_mask,
  input  wire logic       rd_port,
  input  wire logic       rd_hi,
  output logic      [7:0] rd_data,
  output logic      [7:0] lo0,
  output logic      [7:0] hi0,
  output logic      [7:0] lo1,
  output logic      [7:0] hi1
);

  logic [7:0] mem_q [4];
  logic [7:0] mem_d [4];
  logic [7:0] rd_d;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mem_d[i] = mem_q[i];
      if (wr_port[i/2] && (wr_hi == (i % 2 == 1))) begin
        mem_d[i] = (mem_q[i] & ~wr_mask) | (wr_data & wr_mask);
      end
    end
    rd_d = mem_d[{rd_port, rd_hi}];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= RCR_CAP_RESET;
      end
      rd_data <= RCR_CAP_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rd_data <= rd_d;
    end
  end

  assign lo0 = mem_q[0];
  assign hi0 = mem_q[2'h1];
  assign lo1 = mem_q[2'h2];
  assign hi1 = mem_q[2'h3];

endmodule

// ===== hdl/rcr_top.sv
/*
  Remote capability register bank for a two-port serializer.
  Assumes an I2C target decodes the address phase and presents one
  byte access per cycle on reg_*; alt_addr marks the device address + 1.
  Back channel capability words arrive with a one-cycle valid per port.
*/
`timescale 1ns/1ps
// Operation
// (R01) Freeze bit blocks back channel capability loads
// (R02) Unfrozen: back channel loads fields after lock
// (R03) Software overriding fields must set freeze
// (R04) Mode = hi[1:0] above lo bit 6
// (R05) Decode mode: normal, gpio, spi, reserved
// (R06) Single link: only normal mode used
// (R07) Bit 2 shows primary or secondary channel
// (R08) Bit 3 shows two-link capability
// (R09) Bit 1 shows wide video with audio
// (R10) Bit 0 shows forward gpio support
// (R11) Hi bit 3 enables enhanced crc
// (R12) Separate copy per port, selected by 0x1e
// (R13) Second port select reads second copy
// (R14) Select writes second copy; ignored with alt
// (R15) Alt address reaches second port registers
// (R16) Reserved bits read zero; fields reset zero
module rcr_top
  import rcr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       alt_addr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            alt_addr_enable,
  input  wire logic       single_link,
  input  wire logic [1:0] rx_lock,
  input  wire logic [1:0] bc_valid,
  input  wire logic [7:0] bc_lo0,
  input  wire logic [7:0] bc_hi0,
  input  wire logic [7:0] bc_lo1,
  input  wire logic [7:0] bc_hi1,
  output logic      [2:0] mode0,
  output logic      [2:0] mode1,
  output logic      [3:0] caps0,
  output logic      [3:0] caps1,
  output logic      [1:0] crc_enable,
  output logic      [1:0] gpio_fast,
  output logic      [1:0] spi_fwd,
  output logic      [1:0] spi_rev
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] cap_mode(input logic [7:0] lo, input logic [7:0] hi);
    cap_mode = {hi[RCR_HI_MODE_MSB:RCR_HI_MODE_LSB], lo[RCR_LO_MODE0]}; // see (R04)
  endfunction

  function automatic logic [7:0] auto_mask(input logic hi);
    auto_mask = hi ? RCR_HI_AUTO : RCR_LO_AUTO;
  endfunction

  function automatic logic [2:0] mode_use(input logic [2:0] m, input logic single);
    // Class bits: {rev spi, fwd spi, fast gpio}
    mode_use = 3'h0;
    if (!single) begin // see (R06)
      case (rcr_mode_e'(m)) // see (R05)
        RCR_MODE_GPIO1, RCR_MODE_GPIO2, RCR_MODE_GPIO4: mode_use = 3'h1;
        RCR_MODE_FWD_SPI: mode_use = 3'h2;
        RCR_MODE_REV_SPI: mode_use = 3'h4;
        default:          mode_use = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Port select register
  // ----------------------------------------------------------------
  logic [7:0] ps_q, ps_d;
  logic       sel_second;
  logic       hit_ps, hit_lo, hit_hi;

  assign hit_ps = (reg_addr == RCR_PORT_SEL_ADDR);
  assign hit_lo = (reg_addr == RCR_CAP_LO_ADDR);
  assign hit_hi = (reg_addr == RCR_CAP_HI_ADDR);
  // Alt address means port 1 when the alt bit is set; select bit only counts on primary
  assign sel_second = alt_addr ? ps_q[RCR_PS_ALT_ADDR] : // see (R15)
                      (ps_q[RCR_PS_SECOND] && !ps_q[RCR_PS_ALT_ADDR]); // see (R13) (R14)

  always_comb begin
    ps_d = ps_q;
    if (reg_wr && hit_ps && (!alt_addr || ps_q[RCR_PS_ALT_ADDR])) begin // see (R15)
      ps_d = reg_wdata & RCR_PS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Capability store access
  // ----------------------------------------------------------------
  logic [1:0] wr_port;
  logic       wr_hi;
  logic [7:0] wr_data, wr_mask;
  logic [7:0] lo0, hi0, lo1, hi1, store_rd;
  logic [1:0] frozen;
  logic       sw_cap_wr, alt_ok;

  assign frozen  = {lo1[RCR_LO_FREEZE], lo0[RCR_LO_FREEZE]};
  assign alt_ok  = !alt_addr || ps_q[RCR_PS_ALT_ADDR];
  assign sw_cap_wr = reg_wr && (hit_lo || hit_hi) && alt_ok;

  // Software wins over a same-cycle back channel load of the same byte
  always_comb begin
    wr_port = 2'h0;
    wr_hi   = 1'b0;
    wr_data = 8'h00;
    wr_mask = 8'h00;
    if (sw_cap_wr) begin
      wr_port = sel_second ? 2'h2 : 2'h1; // see (R12) (R14)
      wr_hi   = hit_hi;
      wr_data = reg_wdata;
      wr_mask = hit_hi ? RCR_HI_MASK : RCR_LO_MASK; // see (R16) (R11)
    end
  end

  // Loads sit in a per-byte overlay on the software copy, so a write
  // to one byte never drops the loaded value of the other byte
  logic [1:0] bc_load;
  logic [3:0] ov_q, ov_d;
  logic [7:0] bc_q  [4];
  logic [7:0] bc_d  [4];
  logic [7:0] bc_in [4];
  logic [7:0] st    [4];
  logic [7:0] eff   [4];

  assign bc_load = bc_valid & rx_lock & ~frozen; // see (R01) (R02)

  rcr_cap_store u_store (
    .clk     (clk),
    .resetn  (resetn),
    .wr_port (wr_port),
    .wr_hi   (wr_hi),
    .wr_data (wr_data),
    .wr_mask (wr_mask),
    .rd_port (sel_second),
    .rd_hi   (hit_hi),
    .rd_data (store_rd),
    .lo0     (lo0),
    .hi0     (hi0),
    .lo1     (lo1),
    .hi1     (hi1)
  );

  // Byte index is {port, hi}; freeze only blocks new loads
  always_comb begin
    st    = '{lo0, hi0, lo1, hi1};
    bc_in = '{bc_lo0, bc_hi0, bc_lo1, bc_hi1};
    ov_d  = ov_q;
    for (int i = 0; i < 4; i++) begin
      bc_d[i] = bc_q[i];
      if (bc_load[i / 2]) begin
        bc_d[i] = bc_in[i] & auto_mask(i[0]);
        ov_d[i] = 1'b1;
      end
      eff[i] = ov_q[i] ? ((st[i] & ~auto_mask(i[0])) | bc_q[i]) : st[i];
    end
    if (sw_cap_wr) begin
      ov_d[{sel_second, hit_hi}] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;
  logic       rvalid_d, rd_cap_q, rd_ps_q, rd_port_q, rd_hi_q;
  logic [2:0] m0_d, m1_d, u0, u1;

  assign m0_d = cap_mode(eff[0], eff[1]);
  assign m1_d = cap_mode(eff[2], eff[3]);
  assign u0   = mode_use(m0_d, single_link);
  assign u1   = mode_use(m1_d, single_link);

  always_comb begin
    rdata_d  = 8'h00;
    rvalid_d = rd_cap_q || rd_ps_q;
    if (rd_ps_q) begin
      rdata_d = ps_q;
    end else if (rd_cap_q) begin
      // Registered store byte with any loaded bits laid over it
      rdata_d = ov_q[{rd_port_q, rd_hi_q}] ?
                ((store_rd & ~auto_mask(rd_hi_q)) | bc_q[{rd_port_q, rd_hi_q}]) : store_rd;
      rdata_d = rdata_d & (rd_hi_q ? RCR_HI_MASK : RCR_LO_MASK); // see (R16)
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ps_q <= RCR_PS_RESET;
      bc_q <= '{default: RCR_CAP_RESET};
      ov_q <= 4'h0;
      rd_cap_q <= 1'b0;
      rd_ps_q <= 1'b0;
      rd_port_q <= 1'b0;
      rd_hi_q <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      alt_addr_enable <= 1'b0;
      mode0 <= 3'h0;
      mode1 <= 3'h0;
      caps0 <= 4'h0;
      caps1 <= 4'h0;
      crc_enable <= 2'h0;
      gpio_fast <= 2'h0;
      spi_fwd <= 2'h0;
      spi_rev <= 2'h0;
    end else begin
      ps_q <= ps_d;
      bc_q <= bc_d;
      ov_q <= ov_d;
      rd_cap_q <= reg_rd && (hit_lo || hit_hi) && alt_ok;
      rd_ps_q <= reg_rd && hit_ps && alt_ok; // see (R15)
      rd_port_q <= sel_second;
      rd_hi_q <= hit_hi;
      reg_rdata <= rdata_d;
      reg_rvalid <= rvalid_d;
      alt_addr_enable <= ps_q[RCR_PS_ALT_ADDR];
      mode0 <= m0_d;
      mode1 <= m1_d;
      // {two link, channel, wide video, fwd gpio}
      caps0 <= {eff[0][RCR_LO_TWO_LINK], eff[0][RCR_LO_CHANNEL], // see (R08) (R07)
                eff[0][RCR_LO_WIDE_VID], eff[0][RCR_LO_FWD_GPIO]}; // see (R09) (R10)
      caps1 <= {eff[2][RCR_LO_TWO_LINK], eff[2][RCR_LO_CHANNEL],
                eff[2][RCR_LO_WIDE_VID], eff[2][RCR_LO_FWD_GPIO]};
      crc_enable <= {hi1[RCR_HI_CRC], hi0[RCR_HI_CRC]}; // see (R11)
      gpio_fast <= {u1[0], u0[0]};
      spi_fwd <= {u1[1], u0[1]};
      spi_rev <= {u1[2], u0[2]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_freeze_holds;
    @(posedge clk) disable iff (!resetn)
      (frozen[0] && !sw_cap_wr) |=> ($stable(eff[0]) || !frozen[0]);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) else $error("frozen caps changed"); // see (R01)

  property p_load;
    @(posedge clk) disable iff (!resetn)
      (bc_load[0] && !sw_cap_wr) |=> ##1 (caps0 == $past(bc_lo0[3:0], 2));
  endproperty
  a_load: assert property (p_load) else $error("back channel load missing"); // see (R02)

  property p_mode_join;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> (mode0 == {$past(eff[1][1:0]), $past(eff[0][6])});
  endproperty
  a_mode_join: assert property (p_mode_join) else $error("mode bits misordered"); // see (R04)

  property p_single;
    @(posedge clk) disable iff (!resetn)
      single_link |=> (gpio_fast == 2'h0 && spi_fwd == 2'h0 && spi_rev == 2'h0);
  endproperty
  a_single: assert property (p_single) else $error("fast mode in single link"); // see (R06)

  property p_spi_fwd;
    @(posedge clk) disable iff (!resetn)
      (!single_link && m0_d == 3'h6) |=> spi_fwd[0] && !gpio_fast[0];
  endproperty
  a_spi_fwd: assert property (p_spi_fwd) else $error("mode decode wrong"); // see (R05)

  property p_rsvd_zero;
    @(posedge clk) disable iff (!resetn)
      (reg_rvalid && !$past(rd_ps_q)) |-> (reg_rdata[5:4] == 2'h0 && !($past(rd_hi_q)
        && (reg_rdata[7:4] != 4'h0 || reg_rdata[2])));
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // see (R16)

  sequence s_rd_cap;
    reg_rd && (hit_lo || hit_hi) && alt_ok;
  endsequence
  property p_rd_latency;
    @(posedge clk) disable iff (!resetn)
      s_rd_cap |-> ##2 reg_rvalid;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer late"); // see (R12)

  property p_sel_ignored;
    @(posedge clk) disable iff (!resetn)
      (sw_cap_wr && !alt_addr && ps_q[RCR_PS_ALT_ADDR]) |=> ($stable(lo1) && $stable(hi1));
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("select not ignored"); // see (R14)

  property p_alt;
    @(posedge clk) disable iff (!resetn)
      (sw_cap_wr && alt_addr) |=> ($stable(lo0) && $stable(hi0));
  endproperty
  a_alt: assert property (p_alt) else $error("alt address wrong port"); // see (R15) (R13)

endmodule

// ===== sim/rcr_remote_model.sv
/*
  Behavioural remote receiver: drives lock and per-port capability
  words with a one-cycle valid. Assumes tasks are called at negedge clk.
*/
`timescale 1ns/1ps
module rcr_remote_model (
  input  wire logic       clk,
  output logic      [1:0] rx_lock,
  output logic      [1:0] bc_valid,
  output logic      [7:0] bc_lo0,
  output logic      [7:0] bc_hi0,
  output logic      [7:0] bc_lo1,
  output logic      [7:0] bc_hi1
);
  initial begin
    rx_lock  = 2'h0;
    bc_valid = 2'h0;
    bc_lo0   = 8'h00;
    bc_hi0   = 8'h00;
    bc_lo1   = 8'h00;
    bc_hi1   = 8'h00;
  end

  task automatic set_lock(input logic [1:0] l);
    rx_lock = l;
    @(negedge clk);
  endtask

  // Words are valid for one cycle only
  task automatic send(input logic p, input logic [7:0] lo, input logic [7:0] hi);
    if (p) begin
      bc_lo1 = lo;
      bc_hi1 = hi;
    end else begin
      bc_lo0 = lo;
      bc_hi0 = hi;
    end
    bc_valid[p] = 1'b1;
    @(negedge clk);
    bc_valid = 2'h0;
    // Stale bytes inverted so a load outside valid shows up
    if (p) begin
      bc_lo1 = ~lo;
      bc_hi1 = ~hi;
    end else begin
      bc_lo0 = ~lo;
      bc_hi0 = ~hi;
    end
    // Let an edge pass so back-to-back sends never re-drive valid at once
    @(negedge clk);
  endtask
endmodule

// ===== sim/rcr_top_tb.sv
/*
  Self-checking bench for rcr_top with the remote receiver model.
  Assumes one clock; all inputs change at the falling edge.
*/
`timescale 1ns/1ps
module rcr_top_tb;
  import rcr_pkg::*;

  logic       clk;
  logic       resetn;
  logic       reg_wr;
  logic       reg_rd;
  logic       alt_addr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       alt_addr_enable;
  logic       single_link;
  logic [1:0] rx_lock;
  logic [1:0] bc_valid;
  logic [7:0] bc_lo0;
  logic [7:0] bc_hi0;
  logic [7:0] bc_lo1;
  logic [7:0] bc_hi1;
  logic [2:0] mode0;
  logic [2:0] mode1;
  logic [3:0] caps0;
  logic [3:0] caps1;
  logic [1:0] crc_enable;
  logic [1:0] gpio_fast;
  logic [1:0] spi_fwd;
  logic [1:0] spi_rev;
  int         n_errors;
  int         cmp_count;
  int         cycles;

  rcr_top u_rcr_top (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .alt_addr(alt_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alt_addr_enable(alt_addr_enable),
    .single_link(single_link), .rx_lock(rx_lock), .bc_valid(bc_valid),
    .bc_lo0(bc_lo0), .bc_hi0(bc_hi0), .bc_lo1(bc_lo1), .bc_hi1(bc_hi1),
    .mode0(mode0), .mode1(mode1), .caps0(caps0), .caps1(caps1),
    .crc_enable(crc_enable), .gpio_fast(gpio_fast), .spi_fwd(spi_fwd), .spi_rev(spi_rev));

  rcr_remote_model u_rcr_remote_model (.clk(clk), .rx_lock(rx_lock), .bc_valid(bc_valid),
    .bc_lo0(bc_lo0), .bc_hi0(bc_hi0), .bc_lo1(bc_lo1), .bc_hi1(bc_hi1));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run is well under 1000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic alt);
    reg_addr  = a;
    reg_wdata = d;
    alt_addr  = alt;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // One idle edge so the next call never re-drives the strobe at once
    @(negedge clk);
  endtask

  // Read; ok flags whether any answer came within three cycles
  task automatic rc(input logic [7:0] a, input logic alt, input logic [7:0] exp,
                    input logic exp_ok);
    logic [7:0] d;
    logic       ok;
    d        = 8'h00;
    ok       = 1'b0;
    reg_addr = a;
    alt_addr = alt;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      if (reg_rvalid === 1'b1 && !ok) begin
        ok = 1'b1;
        d  = reg_rdata;
      end
    end
    check("rvalid", {7'h0, ok}, {7'h0, exp_ok});
    if (exp_ok) check("rdata", d, exp);
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rc(RCR_CAP_LO_ADDR, 1'b0, 8'h00, 1'b1);
    rc(RCR_CAP_HI_ADDR, 1'b0, 8'h00, 1'b1);
    rc(RCR_PORT_SEL_ADDR, 1'b0, RCR_PS_RESET, 1'b1);
    check("caps0", {4'h0, caps0}, 8'h00);
  endtask

  task automatic t_override();
    logic [2:0] mv;
    wr(RCR_CAP_LO_ADDR, 8'hff, 1'b0);
    wr(RCR_CAP_HI_ADDR, 8'hff, 1'b0);
    rc(RCR_CAP_LO_ADDR, 1'b0, 8'hcf, 1'b1);
    rc(RCR_CAP_HI_ADDR, 1'b0, 8'h0b, 1'b1);
    check("caps0", {4'h0, caps0}, 8'h0f);
    check("crc", {6'h0, crc_enable}, 8'h01);
    u_rcr_remote_model.set_lock(2'h1);
    u_rcr_remote_model.send(1'b0, 8'h00, 8'h00);
    settle();
    rc(RCR_CAP_LO_ADDR, 1'b0, 8'hcf, 1'b1);
    rc(RCR_CAP_HI_ADDR, 1'b0, 8'h0b, 1'b1);
    wr(RCR_CAP_LO_ADDR, 8'h84, 1'b0);
    settle();
    check("channel bit", {4'h0, caps0}, 8'h04);
    for (int s = 0; s < 2; s++) begin
      single_link = s[0];
      for (int m = 0; m < 8; m++) begin
        mv = m[2:0];
        wr(RCR_CAP_LO_ADDR, {1'b1, mv[0], 6'h00}, 1'b0);
        wr(RCR_CAP_HI_ADDR, {6'h00, mv[2:1]}, 1'b0);
        settle();
        check("mode0", {5'h0, mode0}, {5'h0, mv});
        check("gpio_fast", {7'h0, gpio_fast[0]}, {7'h0, s == 0 && m >= 1 && m <= 3});
        check("spi_fwd", {7'h0, spi_fwd[0]}, {7'h0, s == 0 && m == 6});
        check("spi_rev", {7'h0, spi_rev[0]}, {7'h0, s == 0 && m == 7});
      end
    end
    single_link = 1'b0;
  endtask

  task automatic t_auto();
    wr(RCR_CAP_LO_ADDR, 8'h00, 1'b0);
    wr(RCR_CAP_HI_ADDR, 8'h00, 1'b0);
    u_rcr_remote_model.set_lock(2'h0);
    u_rcr_remote_model.send(1'b0, 8'hff, 8'hff);
    settle();
    rc(RCR_CAP_LO_ADDR, 1'b0, 8'h00, 1'b1);
    u_rcr_remote_model.set_lock(2'h3);
    u_rcr_remote_model.send(1'b0, 8'hff, 8'hff);
    settle();
    rc(RCR_CAP_LO_ADDR, 1'b0, RCR_LO_AUTO, 1'b1);
    rc(RCR_CAP_HI_ADDR, 1'b0, RCR_HI_AUTO, 1'b1);
    check("mode0", {5'h0, mode0}, 8'h07);
  endtask

  task automatic t_ports();
    u_rcr_remote_model.send(1'b1, 8'h0a, 8'h02);
    settle();
    rc(RCR_CAP_LO_ADDR, 1'b0, RCR_LO_AUTO, 1'b1);
    check("caps1", {4'h0, caps1}, 8'h0a);
    check("mode1", {5'h0, mode1}, 8'h04);
    check("fast1", {5'h0, gpio_fast[1], spi_fwd[1], spi_rev[1]}, 8'h00);
    wr(RCR_PORT_SEL_ADDR, 8'h02, 1'b0);
    rc(RCR_CAP_LO_ADDR, 1'b0, 8'h0a, 1'b1);
    wr(RCR_CAP_HI_ADDR, 8'h08, 1'b0);
    settle();
    check("crc", {6'h0, crc_enable}, 8'h02);
    wr(RCR_CAP_LO_ADDR, 8'hc0, 1'b1);
    rc(RCR_CAP_LO_ADDR, 1'b1, 8'h00, 1'b0);
    wr(RCR_PORT_SEL_ADDR, 8'h06, 1'b0);
    settle();
    check("alt_en", {7'h0, alt_addr_enable}, 8'h01);
    rc(RCR_CAP_LO_ADDR, 1'b0, RCR_LO_AUTO, 1'b1);
    rc(RCR_CAP_LO_ADDR, 1'b1, 8'h0a, 1'b1);
    rc(RCR_CAP_HI_ADDR, 1'b1, 8'h08, 1'b1);
    rc(RCR_PORT_SEL_ADDR, 1'b1, 8'h06, 1'b1);
    // Primary write with alt enabled goes to port 0; alt write to port 1
    wr(RCR_CAP_HI_ADDR, 8'h08, 1'b0);
    wr(RCR_CAP_LO_ADDR, 8'h81, 1'b1);
    settle();
    check("crc", {6'h0, crc_enable}, 8'h03);
    check("caps1", {4'h0, caps1}, 8'h01);
    rc(RCR_CAP_LO_ADDR, 1'b1, 8'h81, 1'b1);
    rc(8'h22, 1'b0, 8'h00, 1'b0);
  endtask

  initial begin
    n_errors    = 0;
    cmp_count   = 0;
    cycles      = 0;
    resetn      = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    alt_addr    = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    single_link = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_reset();
    t_override();
    t_auto();
    t_ports();
    summarize();
  end
endmodule
